// >>> hdl/ecp_fifo.sv
`timescale 1ns/1ns
module ecp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0]      count, next_count;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out  = (count != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // Pointer and count update; flush empties without touching storage
  always_comb begin
    next_wr_ptr = push ? wr_ptr + PW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + PW'(1) : rd_ptr;
    next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
    if (flush_in) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule : ecp_fifo

// >>> hdl/ecp_pkg.sv
package ecp_pkg;
  // Port word and shared FIFO sizing
  localparam int unsigned PWORD_W    = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned RLE_MAX    = 64;
  localparam int unsigned HADDR_W    = 13;
  localparam int unsigned SYNC_W     = 13;

  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_DATA    = 11'h000;
  localparam logic [10:0] IDX_STATUS  = 11'h001;
  localparam logic [10:0] IDX_CONTROL = 11'h002;
  localparam logic [10:0] IDX_FIFO    = 11'h400;
  localparam logic [10:0] IDX_CFGB    = 11'h401;
  localparam logic [10:0] IDX_ECR     = 11'h402;

  // Values after reset and constant patterns
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DCR_RESET  = 8'h04;
  localparam logic [7:0] ECR_RESET  = 8'h14;
  localparam logic [7:0] CFGA_VALUE = 8'h10;

  // Control register bit positions
  localparam int unsigned DCR_STROBE = 0;
  localparam int unsigned DCR_AUTOFD = 1;
  localparam int unsigned DCR_INIT   = 2;
  localparam int unsigned DCR_SELIN  = 3;
  localparam int unsigned DCR_ACKIEN = 4;
  localparam int unsigned DCR_DIR    = 5;

  // Extended control register bit positions
  localparam int unsigned ECR_MODE_LSB = 5;
  localparam int unsigned ECR_FLTDIS   = 4;
  localparam int unsigned ECR_DMA_ENABLE    = 3;
  localparam int unsigned ECR_SERVICE  = 2;

  typedef enum logic [2:0] {
    MODE_SPP  = 3'b000,
    MODE_PS2  = 3'b001,
    MODE_FIFO = 3'b010,
    MODE_ECP  = 3'b011,
    MODE_EPP  = 3'b100,
    MODE_RSV  = 3'b101,
    MODE_TEST = 3'b110,
    MODE_CFG  = 3'b111
  } ecp_mode_t;

  // One FIFO entry: cmd set for an address or run-length byte
  typedef struct packed {
    logic       cmd;
    logic [7:0] value;
  } ecp_word_t;
endpackage : ecp_pkg

// >>> hdl/ecp_port.sv
// Notes on behaviour
// [R1] - Every port word on the host data path is eight bits.
// [R2] - All four FIFO views share one sixteen-byte store.
// [R3] - The FIFO buffers both directions and holds sixteen entries.
// [R4] - Only one direction moves at a time, chosen by the direction bit.
// [R5] - No negotiation; burst channel with DMA requests in both directions.
// [R6] - Standard printer port behaviour whenever extended mode is not selected; FIFO mode (010) drives strobe and data from hardware instead.
// [R7] - FIFO compatibility mode runs strobe and busy handshake in hardware.
// [R8] - Run-length count byte is consumed; next byte repeats that many times.
// [R9] - Decompression is built; compression is not offered.
// [R10] - One count plus one data byte expands to at most 64 bytes.
// [R11] - Forward bytes carry an address or data tag on the autofeed line.
// [R12] - Strobe clocks each forward byte; busy acknowledges before next strobe.
// [R13] - Peripheral ack marks reverse data; autofeed answers as interlock.
// [R14] - Status and control registers answer in every mode.
// [R15] - Configuration B shows the chosen interrupt line and DMA channel.
// [R16] - Address FIFO bit 7 set: channel address; clear: run-length count.
// [R17] - Configuration A reads a constant with only bit 4 set.
// [R18] - FIFO and data offsets select registers by mode field.
// [R19] - Init low turns the channel reverse; paper-error low acknowledges.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module ecp_port (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [12:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Global configuration choices
  input  wire logic [2:0]  irq_select_in,
  input  wire logic [2:0]  dma_select_in,
  output logic             dma_req_out,
  // Parallel cable
  input  wire logic [7:0]  pd_in,
  output logic [7:0]       pd_out,
  output logic             pd_oe_out,
  output logic             strobe_n_out,
  output logic             autofd_n_out,
  output logic             init_n_out,
  output logic             select_in_n_out,
  input  wire logic        busy_in,
  input  wire logic        ack_n_in,
  input  wire logic        perror_in,
  input  wire logic        select_in,
  input  wire logic        fault_n_in
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_STROBE  = 3'b010,
    ST_RELEASE = 3'b011,
    ST_REV_REQ = 3'b100,
    ST_REV_ACK = 3'b101,
    ST_EXPAND  = 3'b110
  } ecp_state_t;

  // Two-flop synchronisers for every cable input
  logic [ecp_pkg::SYNC_W-1:0] sync_a, sync_b, pins_raw;
  assign pins_raw = {pd_in, busy_in, ack_n_in, perror_in, select_in, fault_n_in};
  genvar gi;
  generate
    for (gi = 0; gi < ecp_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pins_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  logic [7:0] pd_s;
  logic       busy_s, ack_n_s, perror_s, select_s, fault_n_s;
  assign {pd_s, busy_s, ack_n_s, perror_s, select_s, fault_n_s} = sync_b;

  // Software-visible state
  logic [7:0]        data_reg, dcr, ecr_ctl, hrdata;
  logic [7:0]        next_data_reg, next_dcr, next_ecr_ctl, next_hrdata;
  logic              flush, next_flush;
  ecp_pkg::ecp_mode_t mode;
  assign mode = ecp_pkg::ecp_mode_t'(ecr_ctl[7:5]);

  // Mode decode: reverse only where the direction bit is honoured
  logic fifo_mode, reverse, fwd_run, rev_run;
  assign fifo_mode = (mode == ecp_pkg::MODE_FIFO) || (mode == ecp_pkg::MODE_ECP);
  assign reverse   = dcr[ecp_pkg::DCR_DIR] && (mode == ecp_pkg::MODE_PS2 ||
                     mode == ecp_pkg::MODE_ECP); // [R4]
  assign fwd_run   = fifo_mode && !reverse;
  assign rev_run   = (mode == ecp_pkg::MODE_ECP) && reverse && !perror_s; // [R19]

  // AHB-Lite address phase capture; reads insert one wait state
  logic        ap_valid, ap_write, rd_done;
  logic        next_ap_valid, next_ap_write, next_rd_done;
  logic [10:0] ap_idx, next_ap_idx;
  logic        wr_stb, rd_stb;
  assign wr_stb        = ap_valid && ap_write;
  assign rd_stb        = ap_valid && !ap_write && !rd_done;
  assign hreadyout_out = !rd_stb;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = {24'h000000, hrdata};

  always_comb begin
    next_ap_valid = ap_valid;
    next_ap_write = ap_write;
    next_ap_idx   = ap_idx;
    next_rd_done  = rd_stb;
    if (hready_in) begin
      next_ap_valid = hsel_in && htrans_in[1];
      next_ap_write = hwrite_in;
      next_ap_idx   = haddr_in[12:2];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_idx   <= 11'h000;
      rd_done  <= 1'b0;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_idx   <= next_ap_idx;
      rd_done  <= next_rd_done;
    end
  end

  // Register decode by mode field; unmapped reads give zero
  logic hit_afifo, hit_fifo, hit_cfga, hit_cfgb, hit_data;
  assign hit_data  = ap_idx == ecp_pkg::IDX_DATA && !mode[2] && !mode[1]; // [R18]
  assign hit_afifo = ap_idx == ecp_pkg::IDX_DATA && mode == ecp_pkg::MODE_ECP; // [R18]
  assign hit_fifo  = ap_idx == ecp_pkg::IDX_FIFO && (fifo_mode || mode == ecp_pkg::MODE_TEST);
  assign hit_cfga  = ap_idx == ecp_pkg::IDX_FIFO && mode == ecp_pkg::MODE_CFG;
  assign hit_cfgb  = ap_idx == ecp_pkg::IDX_CFGB && mode == ecp_pkg::MODE_CFG;

  // Shared FIFO and forward skid buffer
  ecp_pkg::ecp_word_t fifo_in, fifo_out, skid_out, eng_word;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic skid_in_ready, skid_out_valid, eng_take, eng_push, bus_push, bus_pop;
  logic fifo_full, fifo_empty, test_mode;
  assign test_mode  = mode == ecp_pkg::MODE_TEST;
  assign fifo_full  = !fifo_in_ready;
  assign fifo_empty = !fifo_out_valid;
  // Bus fills only in the forward direction or test mode
  assign bus_push = wr_stb && (hit_afifo || hit_fifo) && !reverse; // [R4]
  assign bus_pop  = rd_stb && hit_fifo && (reverse || test_mode);
  assign fifo_in_valid  = rev_run ? eng_push : bus_push;
  assign fifo_in        = rev_run ? eng_word :
                          ecp_pkg::ecp_word_t'({hit_afifo, hwdata_in[7:0]}); // [R1] [R16]
  assign fifo_out_ready = fwd_run ? skid_in_ready : bus_pop;

  ecp_fifo #(
    .WIDTH ($bits(ecp_pkg::ecp_word_t)),
    .DEPTH (ecp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (flush),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out)
  ); // [R2] [R3]

  ecp_skid #(
    .WIDTH ($bits(ecp_pkg::ecp_word_t))
  ) u_skid (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (flush),
    .in_valid_in   (fwd_run && fifo_out_valid),
    .in_ready_out  (skid_in_ready),
    .in_data_in    (fifo_out),
    .out_valid_out (skid_out_valid),
    .out_ready_in  (eng_take),
    .out_data_out  (skid_out)
  );

  // Register writes; a mode change empties the shared FIFO
  always_comb begin
    next_data_reg = data_reg;
    next_dcr      = dcr;
    next_ecr_ctl  = ecr_ctl;
    next_flush    = 1'b0;
    if (wr_stb) begin
      if (hit_data) begin
        next_data_reg = hwdata_in[7:0]; // [R6]
      end
      if (ap_idx == ecp_pkg::IDX_CONTROL) begin
        next_dcr = {2'b00, hwdata_in[5:0]}; // [R14]
      end
      if (ap_idx == ecp_pkg::IDX_ECR) begin
        next_ecr_ctl = {hwdata_in[7:2], 2'b00};
        next_flush   = hwdata_in[7:5] != ecr_ctl[7:5];
      end
    end
  end

  // Read mux, registered in the wait cycle
  logic [7:0] status_view, cfgb_view;
  assign status_view = {~busy_s, ack_n_s, perror_s, select_s, fault_n_s, 3'b000};
  // Compression is not built, so its flag reads zero
  assign cfgb_view = {1'b0, ~fault_n_s & ~ecr_ctl[ecp_pkg::ECR_FLTDIS],
                      irq_select_in, dma_select_in}; // [R9] [R15]
  always_comb begin
    next_hrdata = hrdata;
    if (rd_stb) begin
      next_hrdata = 8'h00;
      unique case (1'b1)
        hit_data:  next_hrdata = reverse ? pd_s : data_reg; // [R6]
        hit_afifo: next_hrdata = 8'h00;
        hit_fifo:  next_hrdata = bus_pop ? fifo_out.value : 8'h00;
        hit_cfga:  next_hrdata = ecp_pkg::CFGA_VALUE; // [R17]
        hit_cfgb:  next_hrdata = cfgb_view;
        (ap_idx == ecp_pkg::IDX_STATUS):  next_hrdata = status_view; // [R14]
        (ap_idx == ecp_pkg::IDX_CONTROL): next_hrdata = dcr; // [R14]
        (ap_idx == ecp_pkg::IDX_ECR):
          next_hrdata = {ecr_ctl[7:2], fifo_full, fifo_empty};
        default:   next_hrdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_reg <= ecp_pkg::DATA_RESET;
      dcr      <= ecp_pkg::DCR_RESET;
      ecr_ctl  <= ecp_pkg::ECR_RESET;
      hrdata   <= 8'h00;
      flush    <= 1'b0;
    end else begin
      data_reg <= next_data_reg;
      dcr      <= next_dcr;
      ecr_ctl  <= next_ecr_ctl;
      hrdata   <= next_hrdata;
      flush    <= next_flush;
    end
  end

  // Pin engine: forward strobe/busy interlock, reverse ack/autofeed
  ecp_state_t state, next_state;
  logic [7:0] out_byte, next_out_byte, held, next_held;
  logic       out_cmd, next_out_cmd, rle_pend, next_rle_pend;
  logic [5:0] rle_left, next_rle_left;
  logic [6:0] rle_clip;
  // Counts beyond the largest run are clipped so one pair never exceeds it
  assign rle_clip = (pd_s[6:0] > 7'(ecp_pkg::RLE_MAX - 1)) ?
                    7'(ecp_pkg::RLE_MAX - 1) : pd_s[6:0]; // [R10]
  assign eng_take = state == ST_IDLE && fwd_run && !busy_s;
  assign eng_word = ecp_pkg::ecp_word_t'({1'b0, held});
  assign eng_push = (state == ST_EXPAND) ||
                    (state == ST_REV_REQ && !ack_n_s && busy_s && !rle_pend);

  always_comb begin
    next_state    = state;
    next_out_byte = out_byte;
    next_out_cmd  = out_cmd;
    next_held     = held;
    next_rle_pend = rle_pend;
    next_rle_left = rle_left;
    unique case (state)
      ST_IDLE: begin
        if (eng_take && skid_out_valid) begin
          next_out_byte = skid_out.value;
          next_out_cmd  = skid_out.cmd; // [R11]
          next_state    = ST_SETUP;
        end else if (rev_run) begin
          next_state = ST_REV_REQ;
        end
      end
      // One cycle of data setup before the strobe falls
      ST_SETUP:   next_state = ST_STROBE;
      ST_STROBE: begin
        if (busy_s) begin
          next_state = ST_RELEASE; // [R12] [R7]
        end
      end
      ST_RELEASE: begin
        if (!busy_s) begin
          next_state = ST_IDLE; // [R12]
        end
      end
      ST_REV_REQ: begin
        next_held = pd_s;
        if (!rev_run) begin
          next_state = ST_IDLE;
        end else if (!ack_n_s) begin
          if (!busy_s) begin
            // Command byte: count when bit 7 clear, else a channel address
            if (!pd_s[7]) begin
              next_rle_pend = 1'b1; // [R16] [R8]
              next_rle_left = rle_clip[5:0];
            end
            next_state = ST_REV_ACK; // [R13]
          end else if (rle_pend) begin
            next_state = ST_EXPAND; // [R8]
          end else if (fifo_in_ready) begin
            next_state = ST_REV_ACK; // [R13]
          end
        end
      end
      // Repeat the byte after a count; the FIFO stalls this as needed
      ST_EXPAND: begin
        if (fifo_in_ready) begin
          next_rle_left = rle_left - 6'h01;
          if (rle_left == 6'h00) begin
            next_rle_pend = 1'b0;
            next_state    = ST_REV_ACK; // [R8]
          end
        end
      end
      ST_REV_ACK: begin
        if (ack_n_s) begin
          next_state = rev_run ? ST_REV_REQ : ST_IDLE; // [R13]
        end
      end
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state    <= ST_IDLE;
      out_byte <= 8'h00;
      out_cmd  <= 1'b0;
      held     <= 8'h00;
      rle_pend <= 1'b0;
      rle_left <= 6'h00;
    end else begin
      state    <= next_state;
      out_byte <= next_out_byte;
      out_cmd  <= next_out_cmd;
      held     <= next_held;
      rle_pend <= next_rle_pend;
      rle_left <= next_rle_left;
    end
  end

  // Pin drive: hardware owns strobe only in FIFO modes, and autofeed only in ECP mode
  logic strobe_hw;
  assign strobe_hw = (state == ST_STROBE) || (state == ST_SETUP && 1'b0);
  always_comb begin
    pd_out          = fifo_mode ? out_byte : data_reg; // [R1]
    pd_oe_out       = !reverse; // [R4]
    strobe_n_out    = fifo_mode ? !strobe_hw : !dcr[ecp_pkg::DCR_STROBE]; // [R7] [R12]
    autofd_n_out    = !dcr[ecp_pkg::DCR_AUTOFD]; // [R6]
    init_n_out      = dcr[ecp_pkg::DCR_INIT];
    select_in_n_out = !dcr[ecp_pkg::DCR_SELIN];
    if (mode == ecp_pkg::MODE_ECP) begin
      init_n_out      = !dcr[ecp_pkg::DCR_DIR]; // [R19]
      select_in_n_out = 1'b1;
      // Forward: high tags data, low tags address; reverse: low requests
      autofd_n_out = reverse ? (state != ST_REV_REQ && state != ST_IDLE) :
                     !out_cmd; // [R11] [R13]
    end
  end

  // DMA request while the FIFO can move a byte in the live direction
  assign dma_req_out = ecr_ctl[ecp_pkg::ECR_DMA_ENABLE] && !ecr_ctl[ecp_pkg::ECR_SERVICE] &&
                       ((fwd_run && fifo_in_ready) || (rev_run && fifo_out_valid)); // [R5]
endmodule : ecp_port

// >>> hdl/ecp_skid.sv
`timescale 1ns/1ns
module ecp_skid #(
  parameter int unsigned WIDTH = 9
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic [WIDTH-1:0] head, tail, next_head, next_tail;
  logic [1:0]       fill, next_fill;
  logic             push, pop;

  assign in_ready_out  = (fill != 2'h2);
  assign out_valid_out = (fill != 2'h0);
  assign out_data_out  = head;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // Two entries so a stalled pin engine never drops a word
  always_comb begin
    next_head = head;
    next_tail = tail;
    next_fill = fill + 2'(push) - 2'(pop);
    if (pop) begin
      next_head = tail;
    end
    if (push) begin
      if (fill == 2'h0 || (fill == 2'h1 && pop)) begin
        next_head = in_data_in;
      end else begin
        next_tail = in_data_in;
      end
    end
    if (flush_in) begin
      next_fill = 2'h0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      head <= '0;
      tail <= '0;
      fill <= 2'h0;
    end else begin
      head <= next_head;
      tail <= next_tail;
      fill <= next_fill;
    end
  end
endmodule : ecp_skid

// >>> testbench/ecp_periph.sv
`timescale 1ns/1ns
module ecp_periph (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] lag_in,
  input  wire logic [7:0] pd_in,
  input  wire logic       strobe_n_in,
  input  wire logic       autofd_n_in,
  input  wire logic       init_n_in,
  output logic [7:0]      pd_out,
  output logic            busy_out,
  output logic            ack_n_out,
  output logic            perror_out
);
  logic [8:0] got[$];
  logic [8:0] rq[$];
  logic [7:0] pd_q   = 8'h00;
  logic       pd_en  = 1'b0;
  logic       busy_f = 1'b0;
  logic       busy_r = 1'b0;
  logic       ack_q  = 1'b1;
  // Released lines show the inverse so a stale byte never looks valid
  assign pd_out     = pd_en ? pd_q : ~pd_q;
  assign busy_out   = init_n_in ? busy_f : busy_r;
  assign ack_n_out  = ack_q;
  assign perror_out = init_n_in;
  // Forward: latch on strobe, busy after lag, drop it after strobe
  always @(negedge clk_sys_in) begin
    if (!strobe_n_in && !busy_f) begin
      got.push_back({autofd_n_in, pd_in});
      repeat (lag_in) @(negedge clk_sys_in);
      @(posedge clk_sys_in) busy_f <= 1'b1;
      do @(negedge clk_sys_in); while (!strobe_n_in);
      @(posedge clk_sys_in) busy_f <= 1'b0;
    end
  end
  // Reverse: data first, ack later, held until autofeed answers
  always @(negedge clk_sys_in) begin
    if (!init_n_in && !autofd_n_in && rq.size() > 0) begin
      @(posedge clk_sys_in);
      {busy_r, pd_q} <= rq.pop_front();
      pd_en          <= 1'b1;
      repeat (lag_in) @(posedge clk_sys_in);
      ack_q <= 1'b0;
      do @(negedge clk_sys_in); while (!autofd_n_in);
      @(posedge clk_sys_in);
      ack_q <= 1'b1;
      pd_en <= 1'b0;
    end
  end
endmodule : ecp_periph

// >>> testbench/ecp_props.sv
`timescale 1ns/1ns
module ecp_props (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        hsel_in,
  input wire logic [12:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic [31:0] hrdata_out,
  input wire logic        dma_req_out,
  input wire logic        busy_in,
  input wire logic [7:0]  pd_out,
  input wire logic        pd_oe_out,
  input wire logic        strobe_n_out,
  input wire logic        autofd_n_out,
  input wire logic        init_n_out,
  input wire logic        select_in_n_out
);
  logic        wr_p, rev_d;
  logic [10:0] ix_p;
  logic [7:0]  ecr, ctl;
  wire take = hsel_in && htrans_in[1] && hready_in;
  wire fwd  = ecr[7:6] == 2'b01 && !ctl[5];
  wire rev  = ecr[7:5] == 3'b011 && ctl[5];
  // Shadow mode and control, snooped off the bus since only ports are visible
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_p  <= 1'b0;
      ix_p  <= 11'h000;
      ecr   <= ecp_pkg::ECR_RESET;
      ctl   <= ecp_pkg::DCR_RESET;
      rev_d <= 1'b0;
    end else begin
      wr_p  <= take && hwrite_in;
      ix_p  <= haddr_in[12:2];
      rev_d <= rev;
      if (wr_p && ix_p == ecp_pkg::IDX_ECR) ecr <= hwdata_in[7:0];
      if (wr_p && ix_p == ecp_pkg::IDX_CONTROL) ctl <= hwdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  chk_rdata_byte: assert property (hrdata_out[31:8] == 24'h000000)
    else $error("wide read data");
  chk_read_wait: assert property (
    take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  chk_fwd_hold: assert property (
    fwd && !strobe_n_out |-> $stable(pd_out) && $stable(autofd_n_out))
    else $error("byte moved under strobe");
  chk_strobe_release: assert property (
    fwd && $rose(strobe_n_out) |-> $past(busy_in, 2) || $past(busy_in, 3) || $past(busy_in, 4))
    else $error("strobe released without busy");
  chk_init_dir: assert property (
    ecr[7:5] == 3'b011 |-> init_n_out == !ctl[5])
    else $error("init not direction");
  chk_oe_reverse: assert property (rev && rev_d |-> !pd_oe_out)
    else $error("driven in reverse");
  chk_spp_pins: assert property (
    ecr[7:5] == 3'b000 |-> strobe_n_out == !ctl[0] && autofd_n_out == !ctl[1]
      && init_n_out == ctl[2] && select_in_n_out == !ctl[3])
    else $error("legacy pins wrong");
  chk_dma_gate: assert property (!ecr[3] || ecr[2] |-> !dma_req_out)
    else $error("dma request while disabled");
  cov_read: cover property (take && !hwrite_in);
  cov_strobe: cover property (fwd && $rose(strobe_n_out));
  cov_reverse: cover property (rev && !init_n_out);
endmodule : ecp_props
bind ecp_port ecp_props ecp_props_i (.*);

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        hsel_in    = 1'b0;
  logic [12:0] haddr_in   = 13'h0000;
  logic [1:0]  htrans_in  = 2'h0;
  logic        hwrite_in  = 1'b0;
  logic [31:0] hwdata_in  = 32'h00000000;
  logic        hreadyout_out, dma_req_out, pd_oe_out, busy_in, ack_n_in, perror_in;
  logic        strobe_n_out, autofd_n_out, init_n_out, select_in_n_out;
  logic [31:0] hrdata_out, rdv;
  logic [7:0]  pd_out, per_pd, pd_wire;
  logic [7:0]  lag        = 8'h02;
  int          num_errors = 0;
  int          checked    = 0;
  int          cyc        = 0;
  localparam logic [10:0] r_dat = ecp_pkg::IDX_DATA, r_sta = ecp_pkg::IDX_STATUS;
  localparam logic [10:0] r_ctl = ecp_pkg::IDX_CONTROL, r_fif = ecp_pkg::IDX_FIFO;
  localparam logic [10:0] r_cfb = ecp_pkg::IDX_CFGB, r_ecr = ecp_pkg::IDX_ECR;
  assign pd_wire = pd_oe_out ? pd_out : per_pd;
  always #5 clk_sys_in = ~clk_sys_in;
  ecp_port ecp_port_i (.*, .hsize_in(3'h2), .hready_in(hreadyout_out), .hresp_out(),
    .irq_select_in(3'h5), .dma_select_in(3'h3), .pd_in(pd_wire), .select_in(1'b1),
    .fault_n_in(1'b1));
  ecp_periph ecp_periph_i (.clk_sys_in, .lag_in(lag), .pd_in(pd_wire),
    .strobe_n_in(strobe_n_out), .autofd_n_in(autofd_n_out), .init_n_in(init_n_out),
    .pd_out(per_pd), .busy_out(busy_in), .ack_n_out(ack_n_in), .perror_out(perror_in));
  task automatic conclude;
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One AHB single transfer; each phase holds until hready is high at a rising edge
  task automatic xfer(input logic w, input logic [10:0] ix, input logic [7:0] d);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in  <= {ix, 2'b00};
    do @(posedge clk_sys_in); while (!hreadyout_out);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h000000, d};
    do @(posedge clk_sys_in); while (!hreadyout_out);
    rdv = hrdata_out;
  endtask : xfer
  task automatic rd(input logic [10:0] ix, input logic [7:0] e);
    xfer(1'b0, ix, 8'h00);
    chk({1'b0, rdv[7:0]}, {1'b0, e});
  endtask : rd
  // Let the flush cycle after a mode change pass
  task automatic setmode(input logic [2:0] m);
    xfer(1'b1, r_ecr, {m, 5'h00});
    @(posedge clk_sys_in);
  endtask : setmode
  task automatic pop(input logic [7:0] e);
    do xfer(1'b0, r_ecr, 8'h00); while (rdv[0]);
    rd(r_fif, e);
  endtask : pop
  // Watchdog against a hung handshake
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(r_ctl, 8'h04);
    rd(r_ecr, 8'h15);
    rd(r_sta, 8'hf8);
    xfer(1'b1, r_dat, 8'h5a);
    rd(r_dat, 8'h5a);
    chk({1'b0, pd_out}, 9'h05a);
    xfer(1'b1, r_ctl, 8'hce);
    rd(r_ctl, 8'h0e);
    xfer(1'b1, r_ctl, 8'h04);
    rd(r_fif, 8'h00);
    rd(11'h003, 8'h00);
    setmode(3'b111);
    rd(r_fif, 8'h10);
    rd(r_cfb, 8'h2b);
    setmode(3'b110);
    xfer(1'b1, r_fif, 8'h3c);
    rd(r_fif, 8'h3c);
    // Stalled printer: fill until full, then drain in order
    ecp_periph_i.got.delete();
    lag <= 8'd100;
    setmode(3'b010);
    for (int i = 0; i < 20; i++) xfer(1'b1, r_fif, i[7:0]);
    rd(r_ecr, 8'h42);
    lag <= 8'd2;
    while (ecp_periph_i.got.size() < 16) @(posedge clk_sys_in);
    for (int i = 0; i < 16; i++) chk({1'b0, ecp_periph_i.got[i][7:0]}, {1'b0, i[7:0]});
    do xfer(1'b0, r_ecr, 8'h00); while (!rdv[0]);
    repeat (60) @(posedge clk_sys_in);
    // Extended forward: address then data, tag on autofeed
    ecp_periph_i.got.delete();
    setmode(3'b011);
    xfer(1'b1, r_dat, 8'h85);
    xfer(1'b1, r_fif, 8'h33);
    while (ecp_periph_i.got.size() < 2) @(posedge clk_sys_in);
    chk(ecp_periph_i.got[0], 9'h085);
    chk(ecp_periph_i.got[1], 9'h133);
    xfer(1'b1, r_ecr, 8'h68);
    @(negedge clk_sys_in);
    chk({8'h00, dma_req_out}, 9'h001);
    @(posedge clk_sys_in);
    xfer(1'b1, r_ecr, 8'h6c);
    xfer(1'b1, r_ecr, 8'h60);
    // Reverse with run-length counts, a dropped address and a clipped count
    ecp_periph_i.rq = {9'h002, 9'h1ab, 9'h081, 9'h17e, 9'h07f, 9'h111};
    xfer(1'b1, r_ctl, 8'h24);
    xfer(1'b1, r_fif, 8'h99);
    for (int i = 0; i < 68; i++) pop(i < 3 ? 8'hab : (i == 3 ? 8'h7e : 8'h11));
    rd(r_ecr, 8'h61);
    conclude();
  end
endmodule : testbench
